// ### msbc_pkg.sv
// Constants and types shared by both ends of the module sideband control.
// Assumes one 125 MHz system clock at each end and APB on the host side.
//
// Notes on behaviour
// - Lowest reset zone holds module in reset.
// - Middle reset zone means normal operation.
// - Highest reset zone means interrupt requested.
// - Host compares at 2.5 V, module 1.25 V.
// - Module interrupt high, host interrupt low.
// - Host reset request active low, same inside.
// - Empty slot reads lowest zone, not presence.
// - Lowest power zone: present and low power.
// - Middle power zone: present, high power allowed.
// - Highest power zone: no module present.
// - Low-power request and presence are active low.
// - Presence at 2.5 V, low power 1.25 V.
// - High to low power within 200 us.
// - Management pins open drain, pull low only.
// - Transmitters stay disabled in low power.
package msbc_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 125;
    localparam int T_HPLP_US = 200;
    localparam int HPLP_CYCLES = T_HPLP_US * CLK_FREQ_MHZ;
    localparam int HPLP_MARGIN = 4;
    localparam int HPLP_CNT_W = 16;

    // ----------------------------------------------------------------
    // Line voltages in millivolts
    // ----------------------------------------------------------------
    localparam logic [11:0] VREF_HOST_MV = 12'h9C4;
    localparam logic [11:0] VREF_MODULE_MV = 12'h4E2;
    localparam logic [11:0] RI_ZONE1_MV = 12'h000;
    localparam logic [11:0] RI_ZONE2_MV = 12'h76C;
    localparam logic [11:0] RI_ZONE3_MV = 12'hBB8;
    localparam logic [11:0] LP_ZONE1_MV = 12'h3B6;
    localparam logic [11:0] LP_ZONE2_MV = 12'h6A4;
    localparam logic [11:0] LP_ZONE3_MV = 12'hCE4;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [1:0] MOD_DECODE_RST = 2'h0;
    localparam logic [1:0] HOST_DECODE_RST = 2'h3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // ----------------------------------------------------------------
    // Host register map
    // ----------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam int CTRL_RESET_N_BIT = 0;
    localparam int CTRL_LOWPOWER_N_BIT = 1;
    localparam int CTRL_SCL_LOW_BIT = 2;
    localparam int CTRL_SDA_LOW_BIT = 3;
    localparam int STAT_INT_N_BIT = 0;
    localparam int STAT_PRESENT_N_BIT = 1;
    localparam int STAT_SCL_BIT = 2;
    localparam int STAT_SDA_BIT = 3;

    // ----------------------------------------------------------------
    // Module power states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        PWR_LOW = 4'h1,
        PWR_UP = 4'h2,
        PWR_HIGH = 4'h4,
        PWR_DOWN = 4'h8
    } msbc_pwr_type;

endpackage

// ### msbc_if.sv
// Sideband lines between host and module, with the analog zones modelled.
// Assumes each end drives only its own outputs; the levels are worked out here.
`timescale 1ns/1ps

interface msbc_if;
    import msbc_pkg::*;

    logic h_reset_drive;
    logic h_lowpower_drive;
    logic m_int_drive;
    logic m_installed;
    logic h_scl_o;
    logic h_scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic scl_level;
    logic sda_level;
    logic [11:0] ri_line_mv;
    logic [11:0] lp_line_mv;
    logic h_ri_above_ref;
    logic h_lp_above_ref;
    logic m_ri_above_ref;
    logic m_lp_above_ref;

    // An empty slot or a host reset request pulls the line into zone 1.
    assign ri_line_mv = (!m_installed || !h_reset_drive) ? RI_ZONE1_MV :
                        (m_int_drive ? RI_ZONE3_MV : RI_ZONE2_MV);
    assign lp_line_mv = !m_installed ? LP_ZONE3_MV :
                        (h_lowpower_drive ? LP_ZONE2_MV : LP_ZONE1_MV);

    assign h_ri_above_ref = ri_line_mv > VREF_HOST_MV;
    assign m_ri_above_ref = ri_line_mv > VREF_MODULE_MV;
    assign h_lp_above_ref = lp_line_mv > VREF_HOST_MV;
    assign m_lp_above_ref = lp_line_mv > VREF_MODULE_MV;

    // The host pull-up holds a pin high unless one side pulls it low.
    assign scl_level = !((h_scl_oe && !h_scl_o) || (m_scl_oe && !m_scl_o));
    assign sda_level = !((h_sda_oe && !h_sda_o) || (m_sda_oe && !m_sda_o));

    modport host_mp (
        output h_reset_drive, h_lowpower_drive,
        output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
        input h_ri_above_ref, h_lp_above_ref, scl_level, sda_level
    );

    modport module_mp (
        output m_int_drive, m_installed,
        output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
        input m_ri_above_ref, m_lp_above_ref, scl_level, sda_level
    );

endinterface

// ### msbc_sync.sv
// Two-flop synchronizer for comparator outputs.
// Assumes the inputs may change at any time relative to i_mclk.
`timescale 1ns/1ps

module msbc_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            meta_q <= RESET_VALUE;
            sync_q <= RESET_VALUE;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

// ### msbc_module_end.sv
// Module end of the sideband control: decodes reset and low power from the
// two multi-level lines and drives interrupt, presence and the open-drain pins.
// Assumes the comparators arrive through msbc_if and that the module's power
// logic reports power-up and power-down completion as levels on i_mclk.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

module msbc_module_end
    import msbc_pkg::*;
#(
    parameter int DEADLINE_CYCLES = HPLP_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    msbc_if.module_mp bus,
    input wire logic i_module_installed,
    input wire logic i_interrupt_request,
    input wire logic i_software_force_low_power,
    input wire logic i_power_up_done,
    input wire logic i_power_down_done,
    input wire logic i_tx_enable_request,
    input wire logic i_scl_pull_low,
    input wire logic i_sda_pull_low,
    output logic o_module_reset_n,
    output logic o_module_lowpower_n,
    output logic o_high_power,
    output logic o_tx_enable,
    output logic [3:0] o_power_state,
    output logic o_deadline_expired,
    output logic o_scl,
    output logic o_sda
);

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------

    // Last count value allowed in power-down before low power is forced.
    // The margin covers the synchronizer and the output register.
    localparam logic [HPLP_CNT_W-1:0] DOWN_LIMIT =
        HPLP_CNT_W'(DEADLINE_CYCLES - HPLP_MARGIN - 1);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [1:0] decode_sync;
    logic module_reset_n;
    logic module_lowpower_n;
    logic lp_req;
    msbc_pwr_type state_q;
    logic [HPLP_CNT_W-1:0] down_cnt_q;
    logic down_timeout;
    logic high_power_q;
    logic tx_enable_q;
    logic expired_q;
    logic int_q;
    logic installed_q;
    logic scl_oe_q;
    logic sda_oe_q;
    logic scl_q;
    logic sda_q;

    // Tells whether a state keeps the module at low power.
    function automatic logic pwr_is_low(input msbc_pwr_type s);
        pwr_is_low = (s == PWR_LOW);
    endfunction

    // ----------------------------------------------------------------
    // Line decode
    // ----------------------------------------------------------------

    // Bit 1 is the reset line above 1.25 V, bit 0 the power line above it.
    msbc_sync #(
        .WIDTH(2),
        .RESET_VALUE(MOD_DECODE_RST)
    ) u_decode_sync (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_async({bus.m_ri_above_ref, bus.m_lp_above_ref}),
        .o_sync(decode_sync)
    );

    // Zone 1 reads as reset asserted; zones 2 and 3 release it.
    assign module_reset_n = decode_sync[1];
    // Zone 1 reads as low power; zone 2 permits high power.
    assign module_lowpower_n = decode_sync[0];

    assign o_module_reset_n = module_reset_n;
    assign o_module_lowpower_n = module_lowpower_n;

    // ----------------------------------------------------------------
    // Power control
    // ----------------------------------------------------------------

    // Any of the three sources sends the module to low power.
    assign lp_req = !module_reset_n || !module_lowpower_n ||
                    i_software_force_low_power;

    assign down_timeout = (down_cnt_q >= DOWN_LIMIT);

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= PWR_LOW;
        end else begin
            case (state_q)
                PWR_LOW: begin
                    if (!lp_req) begin
                        state_q <= PWR_UP;
                    end
                end
                PWR_UP: begin
                    if (lp_req) begin
                        state_q <= PWR_DOWN;
                    end else if (i_power_up_done) begin
                        state_q <= PWR_HIGH;
                    end
                end
                PWR_HIGH: begin
                    if (lp_req) begin
                        state_q <= PWR_DOWN;
                    end
                end
                PWR_DOWN: begin
                    if (i_power_down_done || down_timeout) begin
                        state_q <= PWR_LOW;
                    end
                end
                default: begin
                    state_q <= PWR_LOW;
                end
            endcase
        end
    end

    // Counts the cycles spent in power-down, from zero at entry.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            down_cnt_q <= '0;
        end else if (state_q == PWR_DOWN) begin
            down_cnt_q <= down_cnt_q + 16'h0001;
        end else begin
            down_cnt_q <= '0;
        end
    end

    // Pulses when the deadline, not the power logic, ended power-down.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            expired_q <= 1'b0;
        end else begin
            expired_q <= (state_q == PWR_DOWN) && down_timeout &&
                         !i_power_down_done;
        end
    end

    // ----------------------------------------------------------------
    // Power outputs
    // ----------------------------------------------------------------

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            high_power_q <= 1'b0;
        end else begin
            high_power_q <= !pwr_is_low(state_q);
        end
    end

    // Transmitters run only in full high power with no low-power request.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            tx_enable_q <= 1'b0;
        end else begin
            tx_enable_q <= (state_q == PWR_HIGH) && !lp_req &&
                           i_tx_enable_request;
        end
    end

    assign o_high_power = high_power_q;
    assign o_tx_enable = tx_enable_q;
    assign o_power_state = state_q;
    assign o_deadline_expired = expired_q;

    // ----------------------------------------------------------------
    // Interrupt and presence drive
    // ----------------------------------------------------------------

    // A module held in reset never raises its interrupt.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            int_q <= 1'b0;
        end else begin
            int_q <= module_reset_n && i_interrupt_request;
        end
    end

    // Stands for the presence pull-down that pulls the power line low.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            installed_q <= 1'b0;
        end else begin
            installed_q <= i_module_installed;
        end
    end

    assign bus.m_int_drive = int_q;
    assign bus.m_installed = installed_q;

    // ----------------------------------------------------------------
    // Management pins
    // ----------------------------------------------------------------

    // The module only ever pulls low or lets go.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            scl_oe_q <= i_scl_pull_low;
            sda_oe_q <= i_sda_pull_low;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= bus.scl_level;
            sda_q <= bus.sda_level;
        end
    end

    assign bus.m_scl_o = 1'b0;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_scl_oe = scl_oe_q;
    assign bus.m_sda_oe = sda_oe_q;
    assign o_scl = scl_q;
    assign o_sda = sda_q;

endmodule

// ### msbc_host_end.sv
// Host end of the sideband control: drives reset and low-power requests,
// decodes interrupt and presence, and exposes all of it as APB registers.
// Assumes an APB master on i_mclk and the lines through msbc_if.
`timescale 1ns/1ps

module msbc_host_end
    import msbc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    msbc_if.host_mp bus,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_host_interrupt_n,
    output logic o_host_present_n
);

    logic [3:0] ctrl_q;
    logic [1:0] decode_sync;
    logic scl_q;
    logic sda_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic access;

    // Tells whether an address names a register.
    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == CTRL_OFFSET) || (a == STATUS_OFFSET);
    endfunction

    // ----------------------------------------------------------------
    // Line decode
    // ----------------------------------------------------------------

    // The reset line bit is inverted ahead of the first flop so both decoded bits are active low.
    msbc_sync #(
        .WIDTH(2),
        .RESET_VALUE(HOST_DECODE_RST)
    ) u_decode_sync (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_async({!bus.h_ri_above_ref, bus.h_lp_above_ref}),
        .o_sync(decode_sync)
    );

    // Only zone 3 of the reset line reads as an interrupt.
    assign o_host_interrupt_n = decode_sync[1];
    // Presence comes from the power line alone, never the reset line.
    assign o_host_present_n = decode_sync[0];

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= bus.scl_level;
            sda_q <= bus.sda_level;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign access = i_psel && i_penable && pready_q;

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_q <= CTRL_RST;
        end else if (access && i_pwrite && (i_paddr == CTRL_OFFSET)) begin
            ctrl_q <= i_pwdata[3:0];
        end
    end

    // Answers in the first access cycle; data is latched in setup.
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= i_psel && !i_penable;
            pslverr_q <= i_psel && !i_penable && !addr_mapped(i_paddr);
            prdata_q <= 32'h00000000;
            if (i_psel && !i_penable && !i_pwrite) begin
                if (i_paddr == CTRL_OFFSET) begin
                    prdata_q <= {28'h0000000, ctrl_q};
                end else if (i_paddr == STATUS_OFFSET) begin
                    prdata_q <= {28'h0000000, sda_q, scl_q, decode_sync[0],
                                 decode_sync[1]};
                end
            end
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;

    // ----------------------------------------------------------------
    // Line drive
    // ----------------------------------------------------------------
    assign bus.h_reset_drive = ctrl_q[CTRL_RESET_N_BIT];
    assign bus.h_lowpower_drive = ctrl_q[CTRL_LOWPOWER_N_BIT];
    assign bus.h_scl_o = 1'b0;
    assign bus.h_sda_o = 1'b0;
    assign bus.h_scl_oe = ctrl_q[CTRL_SCL_LOW_BIT];
    assign bus.h_sda_oe = ctrl_q[CTRL_SDA_LOW_BIT];

endmodule

// ### msbc_props.sv
// Checker for the sideband lines joining the host end and the module end.
// Assumes one clock and one active-high asynchronous reset for both ends.
`timescale 1ns/1ps

module msbc_props #(
    parameter int DEADLINE_CYCLES = 20
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic m_int_drive,
    input wire logic h_ri_above_ref,
    input wire logic m_ri_above_ref,
    input wire logic h_lp_above_ref,
    input wire logic m_lp_above_ref,
    input wire logic h_scl_o,
    input wire logic h_scl_oe,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic o_host_interrupt_n,
    input wire logic o_host_present_n,
    input wire logic o_module_reset_n,
    input wire logic o_module_lowpower_n,
    input wire logic o_tx_enable,
    input wire logic [3:0] o_power_state,
    input wire logic o_deadline_expired
);
    // ------
    // Cycles spent in power-down
    // ------
    int down_cnt_q;

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            down_cnt_q <= 0;
        end else if (o_power_state == 4'h8) begin
            down_cnt_q <= down_cnt_q + 1;
        end else begin
            down_cnt_q <= 0;
        end
    end

    default clocking dc @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    // ------
    // Assertions
    // ------
    AST_NO_INT_IN_RESET: assert property (!m_ri_above_ref [*4] |-> !m_int_drive)
        else $error("interrupt driven while module in reset");
    AST_MOD_OUT_OF_RESET: assert property (m_ri_above_ref [*3] |-> o_module_reset_n)
        else $error("module reset not released");
    AST_MOD_IN_RESET: assert property (!m_ri_above_ref [*3] |-> !o_module_reset_n)
        else $error("module reset not taken");
    AST_HOST_INT: assert property (h_ri_above_ref [*3] |-> !o_host_interrupt_n)
        else $error("host interrupt not asserted");
    AST_HOST_NO_INT: assert property (!h_ri_above_ref [*3] |-> o_host_interrupt_n)
        else $error("host interrupt asserted outside top zone");
    AST_PRESENT: assert property (!h_lp_above_ref [*3] |-> !o_host_present_n)
        else $error("presence not shown");
    AST_ABSENT: assert property (h_lp_above_ref [*3] |-> o_host_present_n)
        else $error("presence shown with empty slot");
    AST_LOWPOWER: assert property (!m_lp_above_ref [*3] |-> !o_module_lowpower_n)
        else $error("low power not decoded");
    AST_TX_OFF: assert property (!o_module_lowpower_n |=> !o_tx_enable)
        else $error("transmitter on in low power");
    AST_DOWN_TIME: assert property (o_power_state == 4'h8 |-> down_cnt_q < DEADLINE_CYCLES - 4)
        else $error("power-down exceeds deadline");
    AST_EXPIRED_PULSE: assert property (o_deadline_expired |=> !o_deadline_expired)
        else $error("deadline flag longer than one cycle");
    AST_OPEN_DRAIN: assert property ((h_scl_oe |-> !h_scl_o) and (m_sda_oe |-> !m_sda_o))
        else $error("pin driven high");

    cover property (o_deadline_expired);
    cover property (o_tx_enable);
    cover property (!o_host_interrupt_n);
    cover property (o_host_present_n);
endmodule

// ### testbench.sv
// Self-checking bench: host end and module end joined by the sideband lines.
// Assumes a 125 MHz clock and a shortened power-down deadline.
`timescale 1ns/1ps

module testbench;
    import msbc_pkg::*;
    localparam int DL = 20;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, int_n, prs_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic inst, int_req, force_lp, up_done, dn_done, tx_req, scl_pull, sda_pull;
    logic rst_n, lp_n, hi_pwr, tx_en, expired, m_scl, m_sda;
    logic [3:0] pstate;
    int miscompares, compares, exp_cnt;

    msbc_if msbc_if_i ();
    msbc_host_end msbc_host_end_i (.i_mclk(mclk), .i_reset(rst), .bus(msbc_if_i),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_host_interrupt_n(int_n), .o_host_present_n(prs_n));
    msbc_module_end #(.DEADLINE_CYCLES(DL)) msbc_module_end_i (.i_mclk(mclk),
        .i_reset(rst), .bus(msbc_if_i), .i_module_installed(inst),
        .i_interrupt_request(int_req), .i_software_force_low_power(force_lp),
        .i_power_up_done(up_done), .i_power_down_done(dn_done), .i_tx_enable_request(tx_req),
        .i_scl_pull_low(scl_pull), .i_sda_pull_low(sda_pull), .o_module_reset_n(rst_n),
        .o_module_lowpower_n(lp_n), .o_high_power(hi_pwr), .o_tx_enable(tx_en),
        .o_power_state(pstate), .o_deadline_expired(expired), .o_scl(m_scl), .o_sda(m_sda));
    msbc_props #(.DEADLINE_CYCLES(DL)) msbc_props_i (.i_mclk(mclk), .i_reset(rst),
        .m_int_drive(msbc_if_i.m_int_drive), .h_ri_above_ref(msbc_if_i.h_ri_above_ref),
        .m_ri_above_ref(msbc_if_i.m_ri_above_ref), .h_lp_above_ref(msbc_if_i.h_lp_above_ref),
        .m_lp_above_ref(msbc_if_i.m_lp_above_ref), .h_scl_o(msbc_if_i.h_scl_o),
        .h_scl_oe(msbc_if_i.h_scl_oe), .m_sda_o(msbc_if_i.m_sda_o),
        .m_sda_oe(msbc_if_i.m_sda_oe), .o_host_interrupt_n(int_n), .o_host_present_n(prs_n),
        .o_module_reset_n(rst_n), .o_module_lowpower_n(lp_n), .o_tx_enable(tx_en),
        .o_power_state(pstate), .o_deadline_expired(expired));

    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (expired === 1'h1) begin
            exp_cnt <= exp_cnt + 1;
        end
    end

    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; the read data and the error flag are judged here.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] exp, input logic exp_err);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk);
        while (pready !== 1'h1) begin
            n++;
            if (n > 50) begin
                miscompares++;
                finish_test();
            end
            @(posedge mclk);
        end
        check("pslverr", {31'h0, pslverr}, {31'h0, exp_err});
        if (!wr) begin
            check("prdata", prdata, {28'h0, exp});
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic settle();
        repeat (8) @(posedge mclk);
    endtask

    task automatic wait_state(input logic [3:0] s, output int n);
        n = 0;
        while (pstate !== s) begin
            n++;
            if (n > 200) begin
                miscompares++;
                finish_test();
            end
            @(posedge mclk);
        end
    endtask

    task automatic t_reset_state();
        settle();
        check("reset_n", {31'h0, rst_n}, 32'h0);
        check("lowpower_n", {31'h0, lp_n}, 32'h0);
        check("tx_enable", {31'h0, tx_en}, 32'h0);
        check("int_n", {31'h0, int_n}, 32'h1);
        xfer(1'h0, CTRL_OFFSET, 32'h0, 4'h0, 1'h0);
        xfer(1'h0, STATUS_OFFSET, 32'h0, 4'hD, 1'h0);
        xfer(1'h1, 12'h008, 32'hF, 4'h0, 1'h1);
        xfer(1'h1, STATUS_OFFSET, 32'hF, 4'h0, 1'h0);
        xfer(1'h0, 12'hFFC, 32'h0, 4'h0, 1'h1);
        xfer(1'h0, CTRL_OFFSET, 32'h0, 4'h0, 1'h0);
    endtask

    task automatic t_interrupt();
        xfer(1'h1, CTRL_OFFSET, 32'h1, 4'h0, 1'h0);
        settle();
        check("reset_n", {31'h0, rst_n}, 32'h1);
        check("int_n", {31'h0, int_n}, 32'h0);
        xfer(1'h0, STATUS_OFFSET, 32'h0, 4'hC, 1'h0);
        int_req <= 1'h0;
        settle();
        check("int_n", {31'h0, int_n}, 32'h1);
        int_req <= 1'h1;
        xfer(1'h1, CTRL_OFFSET, 32'h0, 4'h0, 1'h0);
        settle();
        check("reset_n", {31'h0, rst_n}, 32'h0);
        check("int_n", {31'h0, int_n}, 32'h1);
        int_req <= 1'h0;
    endtask

    // Trigger 0 forces low power in software, 1 by the line, 2 by reset.
    task automatic t_power(input int trig);
        int n;
        int ec;
        dn_done <= (trig != 0);
        xfer(1'h1, CTRL_OFFSET, 32'h3, 4'h0, 1'h0);
        wait_state(4'h4, n);
        settle();
        check("lowpower_n", {31'h0, lp_n}, 32'h1);
        check("tx_enable", {31'h0, tx_en}, 32'h1);
        check("high_power", {31'h0, hi_pwr}, 32'h1);
        ec = exp_cnt;
        if (trig == 0) begin
            force_lp <= 1'h1;
        end else begin
            xfer(1'h1, CTRL_OFFSET, (trig == 1) ? 32'h1 : 32'h2, 4'h0, 1'h0);
        end
        wait_state(4'h8, n);
        check("tx_enable", {31'h0, tx_en}, 32'h0);
        wait_state(4'h1, n);
        check("down time", {31'h0, n <= DL - 4}, 32'h1);
        repeat (3) @(posedge mclk);
        check("expired", exp_cnt - ec, (trig == 0) ? 32'h1 : 32'h0);
        check("high_power", {31'h0, hi_pwr}, 32'h0);
        if (trig == 1) begin
            check("lowpower_n", {31'h0, lp_n}, 32'h0);
        end
        force_lp <= 1'h0;
    endtask

    task automatic t_presence();
        inst <= 1'h0;
        xfer(1'h1, CTRL_OFFSET, 32'h1, 4'h0, 1'h0);
        settle();
        check("present_n", {31'h0, prs_n}, 32'h1);
        xfer(1'h0, STATUS_OFFSET, 32'h0, 4'hF, 1'h0);
        inst <= 1'h1;
        settle();
        check("present_n", {31'h0, prs_n}, 32'h0);
    endtask

    task automatic t_open_drain();
        xfer(1'h1, CTRL_OFFSET, 32'h5, 4'h0, 1'h0);
        settle();
        check("scl", {31'h0, m_scl}, 32'h0);
        xfer(1'h0, STATUS_OFFSET, 32'h0, 4'h9, 1'h0);
        sda_pull <= 1'h1;
        xfer(1'h1, CTRL_OFFSET, 32'h1, 4'h0, 1'h0);
        settle();
        check("scl", {31'h0, m_scl}, 32'h1);
        check("sda", {31'h0, m_sda}, 32'h0);
        xfer(1'h0, STATUS_OFFSET, 32'h0, 4'h5, 1'h0);
        sda_pull <= 1'h0;
    endtask

    initial begin
        {rst, inst, int_req, up_done, tx_req} = 5'h1F;
        {psel, penable, pwrite, force_lp, dn_done, scl_pull, sda_pull} = 7'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        t_reset_state();
        t_interrupt();
        for (int t = 0; t < 3; t++) begin
            t_power(t);
        end
        t_presence();
        t_open_drain();
        finish_test();
    end
endmodule
